// *** design/jtag_flash_bridge.sv ***
// What this block does
// - scheme select 00 normal, 10 fast serial
// - test-port load wins, aborts flash load
// - halt stops blank-flash retry loop
// - host reaches flash through test port only
// - bridge drives clock, data, chip select
// - bridge enters user mode despite low complete
// - bytes received over test port, sent serially
// - no self reconfiguration after flash written
// - pulse instruction starts reconfiguration
// - reconfiguration clears bridge, reloads from flash
// - no decompression for test-port loads
`timescale 1ns/1ps
`default_nettype none
`include "bridge_cfg.svh"

module jtag_flash_bridge (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output var logic tdo,
  output var logic tdo_oe,
  input wire logic [1:0] config_scheme_select,
  input wire logic flash_serial_in,
  output var logic flash_serial_clock,
  output var logic flash_serial_out,
  output var logic flash_chip_select_low,
  input wire logic configuration_complete_in,
  output var logic configuration_complete_out,
  output var logic configuration_complete_oe,
  output var logic user_mode,
  output var logic bridge_active,
  output var logic decompress_on
);
  import bridge_pkg::*;

  function automatic logic as_scheme(input logic [1:0] m);
    return (m == `MSEL_AS) || (m == `MSEL_FAST_AS);
  endfunction : as_scheme

  function automatic logic fast_as(input logic [1:0] m);
    return m == `MSEL_FAST_AS;
  endfunction : fast_as

  function automatic logic [7:0] as_byte(input logic [2:0] i);
    if (i == 3'h0) begin
      return `FLASH_READ_CMD;
    end else if (i == 3'h4) begin
      return `BLANK_BYTE;
    end
    return 8'h00;
  endfunction : as_byte

  ////////////////////////////////////////////////////////////////////////
  // test clock domain

  tap_ctl_s ctl;
  logic [`IR_W-1:0] ir_sh_q;
  logic [`IR_W-1:0] ir_q;
  logic [7:0] dr_q;
  logic [7:0] byte_q;
  logic [7:0] rd_tck;
  logic [7:0] rd_q;
  logic [2:0] bcnt_q;
  logic byp_q;
  logic tdo_q;
  logic tdo_oe_q;
  ev_tg_s tg_q;

  tap_fsm u_tap (
    .tck(tck),
    .arst_n(arst_n),
    .tms(tms),
    .ctl(ctl)
  );

  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      ir_sh_q <= '0;
      ir_q <= `IR_BYPASS;
    end else if (ctl.tlr) begin
      ir_q <= `IR_BYPASS;
    end else if (ctl.cap_ir) begin
      ir_sh_q <= `IR_CAPTURE;
    end else if (ctl.sh_ir) begin
      ir_sh_q <= {tdi, ir_sh_q[`IR_W-1:1]};
    end else if (ctl.upd_ir) begin
      ir_q <= ir_sh_q;
    end
  end

  // data register shifts lsb first; a full byte is latched for the flash
  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      dr_q <= '0;
      bcnt_q <= '0;
      byte_q <= '0;
      byp_q <= 1'b0;
    end else if (ctl.cap_dr) begin
      dr_q <= rd_tck;
      bcnt_q <= '0;
      byp_q <= 1'b0;
    end else if (ctl.sh_dr) begin
      dr_q <= {tdi, dr_q[7:1]};
      byp_q <= tdi;
      bcnt_q <= bcnt_q + 3'h1;
      if (ir_q == `IR_FLASH && bcnt_q == 3'h7) begin
        byte_q <= {tdi, dr_q[7:1]};
      end
    end
  end

  // each event flips its own toggle; the other domain sees the change
  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      tg_q <= '0;
    end else begin
      if (ctl.upd_ir && ir_sh_q == `IR_CFG_LOAD) begin
        tg_q.cfg <= ~tg_q.cfg;
      end
      if (ctl.upd_ir && ir_sh_q == `IR_PULSE) begin
        tg_q.reconf <= ~tg_q.reconf;
      end
      if (ctl.upd_ir && ir_sh_q == `IR_HALT) begin
        tg_q.halt <= ~tg_q.halt;
      end
      if (ctl.upd_dr && ir_q == `IR_CFG_LOAD) begin
        tg_q.done <= ~tg_q.done;
      end
      if (ctl.upd_dr && ir_q == `IR_FLASH) begin
        tg_q.fin <= ~tg_q.fin;
      end
      if (ctl.sh_dr && ir_q == `IR_FLASH && bcnt_q == 3'h7) begin
        tg_q.data <= ~tg_q.data;
      end
    end
  end

  always_ff @(negedge tck or negedge arst_n) begin
    if (!arst_n) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_oe_q <= ctl.sh_dr | ctl.sh_ir;
      if (ctl.sh_ir) begin
        tdo_q <= ir_sh_q[0];
      end else if (ir_q == `IR_FLASH || ir_q == `IR_CFG_LOAD) begin
        tdo_q <= dr_q[0];
      end else begin
        tdo_q <= byp_q;
      end
    end
  end

  // last flash byte is stable for a whole byte time before capture
  sync3 #(.W(8)) u_sync_tck (
    .clk(tck),
    .arst_n(arst_n),
    .din(rd_q),
    .dout(rd_tck)
  );

  ////////////////////////////////////////////////////////////////////////
  // reference clock domain: pin and event crossing

  logic [9:0] rsync;
  ev_tg_s tg_s;
  ev_tg_s tg_p_q;
  ev_tg_s ev;
  logic [1:0] msel_s;
  logic miso_s;
  logic done_s;
  logic [`ARM_W-1:0] arm_q;
  logic armed;

  sync3 #(.W(10)) u_sync_ref (
    .clk(ref_clk),
    .arst_n(arst_n),
    .din({tg_q, config_scheme_select, flash_serial_in,
          configuration_complete_in}),
    .dout(rsync)
  );

  assign tg_s = rsync[9:4];
  assign msel_s = rsync[3:2];
  assign miso_s = rsync[1];
  assign done_s = rsync[0];
  assign ev = tg_s ^ tg_p_q;
  assign armed = &arm_q;

  // no load attempt before the synchronisers show the real pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tg_p_q <= '0;
      arm_q <= '0;
    end else begin
      tg_p_q <= tg_s;
      if (!armed) begin
        arm_q <= arm_q + `ARM_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration controller

  cfg_e st_q;
  logic halt_q;
  logic [`RETRY_W-1:0] wait_q;
  logic [2:0] asi_q;
  logic abort;
  logic as_done;
  logic load;
  logic [7:0] load_byte;
  logic busy_q;

  assign abort = ev.cfg | ev.reconf;
  assign as_done = (st_q == C_AS_LOAD) && (asi_q == `AS_SEQ_LEN) && !busy_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= C_IDLE;
    end else if (ev.cfg) begin
      st_q <= C_JTAG_CFG;
    end else if (ev.reconf && st_q != C_JTAG_CFG) begin
      st_q <= C_IDLE;
    end else begin
      unique case (st_q)
        C_IDLE: begin
          if (armed && as_scheme(msel_s) && !halt_q) begin
            st_q <= C_AS_LOAD;
          end
        end
        C_AS_LOAD: begin
          if (as_done) begin
            st_q <= (rd_q == `BLANK_BYTE) ? C_AS_WAIT : C_USER;
          end
        end
        C_AS_WAIT: begin
          if (halt_q) begin
            st_q <= C_HALTED;
          end else if (wait_q == '0) begin
            st_q <= C_AS_LOAD;
          end
        end
        C_JTAG_CFG: begin
          if (ev.done) begin
            st_q <= C_BRIDGE;
          end
        end
        C_HALTED, C_USER, C_BRIDGE: begin
          st_q <= st_q;
        end
        default: begin
          st_q <= C_IDLE;
        end
      endcase
    end
  end

  // halt persists until the device is reset by a reconfiguration
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_q <= 1'b0;
    end else if (ev.halt) begin
      halt_q <= 1'b1;
    end else if (ev.reconf) begin
      halt_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= '0;
    end else if (st_q != C_AS_WAIT) begin
      wait_q <= `RETRY_W'(`AS_RETRY_CYC - 1);
    end else if (wait_q != '0) begin
      wait_q <= wait_q - `RETRY_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      asi_q <= '0;
    end else if (st_q != C_AS_LOAD) begin
      asi_q <= '0;
    end else if (load) begin
      asi_q <= asi_q + 3'h1;
    end
  end

  // byte_q is read across domains: it holds for eight test clocks after
  // its toggle, far longer than the three-stage toggle latency
  always_comb begin
    load = 1'b0;
    load_byte = byte_q;
    if (!abort && !busy_q) begin
      if (st_q == C_BRIDGE && ev.data) begin
        load = 1'b1;
      end else if (st_q == C_AS_LOAD && asi_q < `AS_SEQ_LEN) begin
        load = 1'b1;
        load_byte = as_byte(asi_q);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash serial engine

  logic [`HALF_W-1:0] hp;
  logic [`HALF_W-1:0] div_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [2:0] bitc_q;
  logic sclk_q;
  logic mosi_q;
  logic cs_n_q;
  logic fin_q;

  assign hp = fast_as(msel_s) ? `HALF_W'(`HALF_FAST_CYC) :
              `HALF_W'(`HALF_NORM_CYC);

  // input sampled at the falling edge, not the rising one: the pin
  // synchroniser lags a few cycles, so the whole period must exceed it
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      sh_q <= '0;
      rx_q <= '0;
      rd_q <= '0;
      bitc_q <= '0;
      div_q <= '0;
    end else if (abort) begin
      busy_q <= 1'b0;
      sclk_q <= 1'b0;
    end else if (load) begin
      busy_q <= 1'b1;
      mosi_q <= load_byte[7];
      sh_q <= {load_byte[6:0], 1'b0};
      bitc_q <= '0;
      div_q <= '0;
    end else if (busy_q) begin
      if (div_q == hp - `HALF_W'(1)) begin
        div_q <= '0;
        sclk_q <= ~sclk_q;
        if (sclk_q) begin
          rx_q <= {rx_q[6:0], miso_s};
          if (bitc_q == 3'h7) begin
            busy_q <= 1'b0;
            rd_q <= {rx_q[6:0], miso_s};
          end else begin
            bitc_q <= bitc_q + 3'h1;
            mosi_q <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
          end
        end
      end else begin
        div_q <= div_q + `HALF_W'(1);
      end
    end
  end

  // end of a host frame waits for the byte in flight
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fin_q <= 1'b0;
    end else if (ev.fin && st_q == C_BRIDGE) begin
      fin_q <= 1'b1;
    end else if (abort || (!busy_q && !load)) begin
      fin_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_n_q <= 1'b1;
    end else if (abort) begin
      cs_n_q <= 1'b1;
    end else if (load) begin
      cs_n_q <= 1'b0;
    end else if (as_done || (fin_q && !busy_q)) begin
      cs_n_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status pins

  logic user_q;
  logic bridge_q;
  logic decomp_q;
  logic cc_oe_q;
  logic cc_out_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      user_q <= 1'b0;
      bridge_q <= 1'b0;
      decomp_q <= 1'b0;
      cc_oe_q <= 1'b1;
      cc_out_q <= 1'b0;
    end else begin
      user_q <= (st_q == C_BRIDGE) || (st_q == C_USER && done_s);
      bridge_q <= (st_q == C_BRIDGE);
      decomp_q <= (st_q == C_AS_LOAD);
      cc_oe_q <= !(st_q == C_BRIDGE || st_q == C_USER);
      cc_out_q <= 1'b0;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;
  assign flash_serial_clock = sclk_q;
  assign flash_serial_out = mosi_q;
  assign flash_chip_select_low = cs_n_q;
  assign configuration_complete_out = cc_out_q;
  assign configuration_complete_oe = cc_oe_q;
  assign user_mode = user_q;
  assign bridge_active = bridge_q;
  assign decompress_on = decomp_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_scheme;
    @(posedge ref_clk) disable iff (!arst_n)
      st_q == C_IDLE && !as_scheme(msel_s) && !abort |=> st_q == C_IDLE;
  endproperty
  a_scheme: assert property (p_scheme)
    else $error("load attempt started under a non-serial scheme");

  property p_jtag_wins;
    @(posedge ref_clk) disable iff (!arst_n)
      ev.cfg |=> st_q == C_JTAG_CFG && cs_n_q && !busy_q && !sclk_q;
  endproperty
  a_jtag_wins: assert property (p_jtag_wins)
    else $error("test-port load did not abort the flash load");

  property p_halt;
    @(posedge ref_clk) disable iff (!arst_n)
      st_q == C_AS_WAIT && halt_q && !abort |=> st_q == C_HALTED ##1
      st_q != C_AS_LOAD;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not stop the retry loop");

  property p_idle_pins;
    @(posedge ref_clk) disable iff (!arst_n)
      !busy_q |-> !sclk_q;
  endproperty
  a_idle_pins: assert property (p_idle_pins)
    else $error("serial clock left high with the engine idle");

  property p_user_bridge;
    @(posedge ref_clk) disable iff (!arst_n)
      st_q == C_BRIDGE && !done_s |=> user_q && !cc_oe_q;
  endproperty
  a_user_bridge: assert property (p_user_bridge)
    else $error("bridge not in user mode while complete is low");

  property p_byte_out;
    @(posedge ref_clk) disable iff (!arst_n)
      st_q == C_BRIDGE && ev.data && !busy_q |=> busy_q && !cs_n_q &&
      mosi_q == $past(byte_q[7]);
  endproperty
  a_byte_out: assert property (p_byte_out)
    else $error("received byte was not sent to the flash");

  property p_stay;
    @(posedge ref_clk) disable iff (!arst_n)
      st_q == C_BRIDGE && !ev.cfg && !ev.reconf |=> st_q == C_BRIDGE;
  endproperty
  a_stay: assert property (p_stay)
    else $error("bridge left without a reconfigure instruction");

  property p_reconf;
    @(posedge ref_clk) disable iff (!arst_n)
      st_q == C_BRIDGE && ev.reconf && !ev.cfg |=> st_q == C_IDLE ##1
      !bridge_q && cs_n_q;
  endproperty
  a_reconf: assert property (p_reconf)
    else $error("reconfigure instruction did not clear the bridge");

  property p_no_decomp;
    @(posedge ref_clk) disable iff (!arst_n)
      st_q == C_JTAG_CFG |=> !decomp_q;
  endproperty
  a_no_decomp: assert property (p_no_decomp)
    else $error("decompression active during a test-port load");

endmodule : jtag_flash_bridge

`default_nettype wire

// *** pkg/bridge_cfg.svh ***
`ifndef BRIDGE_CFG_SVH
`define BRIDGE_CFG_SVH

// reference clock
`define CLK_PERIOD_NS 10

// flash serial clock half periods, rounded down to whole cycles
`define FLASH_HALF_NORM_NS 60
`define FLASH_HALF_FAST_NS 40
`define HALF_NORM_CYC ((`FLASH_HALF_NORM_NS) / (`CLK_PERIOD_NS))
`define HALF_FAST_CYC ((`FLASH_HALF_FAST_NS) / (`CLK_PERIOD_NS))
`define HALF_W 4

// pause before another load attempt from a blank flash
`define AS_RETRY_NS 2000
`define AS_RETRY_CYC ((`AS_RETRY_NS) / (`CLK_PERIOD_NS))
`define RETRY_W 8

// power-on settling of the pin synchronisers
`define ARM_W 3

// scheme select decodes
`define MSEL_AS 2'h0
`define MSEL_FAST_AS 2'h2

// instruction register; codes are arbitrary
`define IR_W 4
`define IR_CAPTURE 4'h1
`define IR_CFG_LOAD 4'h2
`define IR_FLASH 4'h3
`define IR_PULSE 4'h4
`define IR_HALT 4'h5
`define IR_BYPASS 4'hf

// flash read used by a load attempt: command, three address bytes, one read
`define FLASH_READ_CMD 8'h03
`define BLANK_BYTE 8'hff
`define AS_SEQ_LEN 3'h5

`endif

// *** pkg/bridge_pkg.sv ***
`include "bridge_cfg.svh"

package bridge_pkg;

  typedef enum logic [3:0] {
    S_TLR = 4'h0, S_RTI = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3,
    S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7,
    S_UPD_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'ha, S_SH_IR = 4'hb,
    S_EX1_IR = 4'hc, S_PA_IR = 4'hd, S_EX2_IR = 4'he, S_UPD_IR = 4'hf
  } tap_state_e;

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_AS_LOAD = 3'h1,
    C_AS_WAIT = 3'h2,
    C_HALTED = 3'h3,
    C_JTAG_CFG = 3'h4,
    C_BRIDGE = 3'h5,
    C_USER = 3'h6
  } cfg_e;

  typedef struct packed {
    logic tlr;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
  } tap_ctl_s;

  // toggles carried from the test clock into the reference clock
  typedef struct packed {
    logic cfg;
    logic done;
    logic reconf;
    logic halt;
    logic data;
    logic fin;
  } ev_tg_s;

endpackage : bridge_pkg

// *** design/sync3.sv ***
`timescale 1ns/1ps
`default_nettype none

module sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output var logic [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once the last two stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        dout[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        dout[i] <= s3_q[i];
      end
    end
  end

endmodule : sync3

`default_nettype wire

// *** design/tap_fsm.sv ***
`timescale 1ns/1ps
`default_nettype none

module tap_fsm (
  input wire logic tck,
  input wire logic arst_n,
  input wire logic tms,
  output var bridge_pkg::tap_ctl_s ctl
);
  import bridge_pkg::*;

  tap_state_e st_q;
  tap_state_e st_d;

  always_comb begin
    unique case (st_q)
      S_TLR: st_d = tms ? S_TLR : S_RTI;
      S_RTI: st_d = tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: st_d = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: st_d = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR: st_d = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: st_d = tms ? S_UPD_DR : S_PA_DR;
      S_PA_DR: st_d = tms ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: st_d = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: st_d = tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: st_d = tms ? S_TLR : S_CAP_IR;
      S_CAP_IR: st_d = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR: st_d = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: st_d = tms ? S_UPD_IR : S_PA_IR;
      S_PA_IR: st_d = tms ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: st_d = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: st_d = tms ? S_SEL_DR : S_RTI;
    endcase
  end

  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_TLR;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    ctl.tlr = (st_q == S_TLR);
    ctl.cap_dr = (st_q == S_CAP_DR);
    ctl.sh_dr = (st_q == S_SH_DR);
    ctl.upd_dr = (st_q == S_UPD_DR);
    ctl.cap_ir = (st_q == S_CAP_IR);
    ctl.sh_ir = (st_q == S_SH_IR);
    ctl.upd_ir = (st_q == S_UPD_IR);
  end

  property p_tlr_escape;
    @(posedge tck) disable iff (!arst_n)
      tms [*5] |=> st_q == S_TLR;
  endproperty
  a_tlr_escape: assert property (p_tlr_escape)
    else $error("five tms highs did not reach test-logic-reset");

endmodule : tap_fsm

`default_nettype wire

// *** sim/flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module flash_model (
  input wire logic ref_clk,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [7:0] rd_byte,
  output var logic miso,
  output var logic [7:0] rx_byte,
  output var logic rx_tg
);
  logic [7:0] sh_q;
  int rcnt = 0;
  int tcnt = 0;
  logic idle_q = 1'b0;
  logic tg_q = 1'b0;

  assign rx_tg = tg_q;

  ////////////////////////////////////////////////////////////////////////////
  // incoming bytes, msb first on rising clock
  always @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rcnt <= 0;
    end else begin
      sh_q <= {sh_q[6:0], mosi};
      rcnt <= rcnt + 1;
      if (rcnt[2:0] == 3'h7) begin
        rx_byte <= {sh_q[6:0], mosi};
        tg_q <= ~tg_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answer advances on falling clock; fifth byte carries the read data
  always @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tcnt <= 0;
    end else begin
      tcnt <= tcnt + 1;
    end
  end

  // released line toggles so a stale bit never passes for data
  always @(posedge ref_clk) begin
    idle_q <= ~idle_q;
  end

  always_comb begin
    if (cs_n) begin
      miso = idle_q;
    end else if (tcnt >= 32 && tcnt < 40) begin
      miso = rd_byte[39-tcnt];
    end else begin
      miso = tcnt[0];
    end
  end
endmodule : flash_model

`default_nettype wire

// *** sim/tb_jtag_flash_bridge.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_jtag_flash_bridge;
  logic ref_clk = 0, arst_n = 0, tck = 0, tms = 1, tdi = 0;
  logic slaves_low = 1;
  logic [1:0] scheme = 2'h0;
  logic [7:0] rd_byte = 8'hff;
  logic [7:0] b0, b1, rx_byte;
  logic tdo, tdo_oe, sclk, mosi, cs_n, miso, cc_out, cc_oe;
  logic user_mode, bact, dec, rx_tg;
  wire cc_wire;
  int fail_count = 0, checked = 0, cyc = 0;
  logic [7:0] exp_q[$];

  // open-drain complete wire with pull-up
  assign cc_wire = !(cc_oe && !cc_out) && !slaves_low;

  jtag_flash_bridge dut_u (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tck(tck),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .config_scheme_select(scheme),
    .flash_serial_in(miso),
    .flash_serial_clock(sclk),
    .flash_serial_out(mosi),
    .flash_chip_select_low(cs_n),
    .configuration_complete_in(cc_wire),
    .configuration_complete_out(cc_out),
    .configuration_complete_oe(cc_oe),
    .user_mode(user_mode),
    .bridge_active(bact),
    .decompress_on(dec)
  );

  flash_model fl_u (
    .ref_clk(ref_clk),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .rd_byte(rd_byte),
    .miso(miso),
    .rx_byte(rx_byte),
    .rx_tg(rx_tg)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic a, input logic e);
    checked++;
    if (a !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
      fail_count++;
    end
  endtask : chk

  task automatic chk8(input logic [7:0] a, input logic [7:0] e);
    checked++;
    if (a !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
      fail_count++;
    end
  endtask : chk8

  task finish_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test clock stands still between calls
  task tk(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    #80 tck = 1;
    #80 tck = 0;
  endtask : tk

  task ir(input logic [3:0] c);
    logic [3:0] cap;
    tk(1, 0);
    tk(1, 0);
    tk(0, 0);
    tk(0, 0);
    #1;
    chk(tdo_oe, 1);
    for (int i = 0; i < 4; i++) begin
      cap[i] = tdo;
      tk(i == 3, c[i]);
      #1;
    end
    chk8({4'h0, cap}, 8'h01);
    tk(1, 0);
    tk(0, 0);
  endtask : ir

  task dr(input logic [15:0] v, input int n);
    tk(1, 0);
    tk(0, 0);
    tk(0, 0);
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, v[i]);
    end
    tk(1, 0);
    tk(0, 0);
  endtask : dr

  task wait_cs(input logic v);
    int k;
    k = 0;
    while (cs_n !== v && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    chk(cs_n, v);
  endtask : wait_cs

  // high result means chip select never fell
  task quiet(input int n, output logic ok);
    ok = 1;
    repeat (n) begin
      @(posedge ref_clk);
      if (cs_n !== 1'b1) ok = 0;
    end
  endtask : quiet

  // flash bytes are compared in arrival order against the notes
  // armed after time zero so the toggle settling from unknown is not a byte
  initial begin
    #1;
    forever begin
      @(rx_tg);
      #1;
      if (exp_q.size() > 0) chk8(rx_byte, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic ok;
    void'($urandom(73896));
    exp_q = '{8'h03, 8'h00, 8'h00, 8'h00};
    fork
      repeat (2) begin
        #10 tck = 1;
        #10 tck = 0;
      end
      repeat (6) @(posedge ref_clk);
    join
    chk(cs_n, 1);
    chk(bact, 0);
    chk(cc_oe, 1);
    chk(cc_out, 0);
    arst_n <= 1;
    tk(0, 0);
    wait_cs(0);
    chk(dec, 1);
    wait_cs(1);
    chk(exp_q.size() == 0, 1);
    wait_cs(0);
    wait_cs(1);
    ir(4'h5);
    quiet(600, ok);
    chk(ok, 1);
    ir(4'h4);
    wait_cs(0);
    // host loads the bridge only into this master
    ir(4'h2);
    repeat (30) @(posedge ref_clk);
    quiet(600, ok);
    chk(ok, 1);
    chk(dec, 0);
    dr(16'h00a5, 8);
    repeat (10) @(posedge ref_clk);
    chk(bact, 1);
    chk(user_mode, 1);
    chk(cc_oe, 0);
    chk(cc_out, 0);
    // two bytes back to back in one shift stay
    ir(4'h3);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    exp_q.push_back(b0);
    exp_q.push_back(b1);
    dr({b1, b0}, 16);
    wait_cs(1);
    chk(exp_q.size() == 0, 1);
    quiet(500, ok);
    chk(ok, 1);
    chk(bact, 1);
    @(posedge ref_clk);
    scheme <= 2'h2;
    rd_byte <= 8'h5a;
    slaves_low <= 0;
    exp_q = '{8'h03, 8'h00, 8'h00, 8'h00};
    ir(4'h4);
    chk(bact, 0);
    wait_cs(0);
    wait_cs(1);
    repeat (10) @(posedge ref_clk);
    chk(user_mode, 1);
    chk(exp_q.size() == 0, 1);
    // unsupported scheme must not start a load
    @(posedge ref_clk);
    scheme <= 2'h1;
    ir(4'h4);
    quiet(600, ok);
    chk(ok, 1);
    chk(user_mode, 0);
    finish_test();
  end
endmodule : tb_jtag_flash_bridge

`default_nettype wire
